// ### decoder_filter_ctrl_clock_measure.sv
// Decoder/filter control register, interrupt routing and clock measurement
`timescale 1ns/1ns
`default_nettype none
module decoder_filter_ctrl_clock_measure #(
  parameter int TICK_CYCLES = decoder_filter_ctrl_pkg::TICK_CYCLES_DEF,
  parameter int WINDOW_TICKS = decoder_filter_ctrl_pkg::WINDOW_TICKS_DEF
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [decoder_filter_ctrl_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [decoder_filter_ctrl_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Port output bits and decoder/filter events
  input wire logic port_output_p0_3,
  input wire logic port_output_p2_0,
  input wire logic [2:0] sync_bit_pulse,
  input wire logic [decoder_filter_ctrl_pkg::FILT_N-1:0] filter_buf_flag,
  // Decoder controls
  output logic dec1_run,
  output logic dec2_run,
  output logic dec1_diff_mode,
  output logic dec2_diff_mode,
  output logic decoder_clock_slow,
  // Interrupts
  output logic irq_supervisory,
  output logic irq_signal,
  output logic irq
);
  import decoder_filter_ctrl_pkg::*;

  logic [ADDR_W-1:0] aw_addr_q;
  logic [15:0] w_data_q;
  logic [1:0] w_strb_q;
  logic dec_one_en;
  logic dec_two_en;
  logic clk_slow_sel;
  logic [IRQ_EN_N-1:0] filt_irq_en;
  logic irq_core_sel;
  logic signal_core_enable_flag;
  logic [1:0] meas_sel_sup;
  logic [1:0] meas_sel_sig;
  logic [EV_W-1:0] ev_status;
  logic [EV_W-1:0] ev_mask;
  meas_state_e meas_state;
  logic [15:0] div_cnt;
  logic [15:0] tick_cnt;
  logic [15:0] sync_count;
  logic [1:0] meas_dec;
  logic [15:0] result;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Write path decode
  wire wr_fire = !awready && !wready && !bvalid;
  wire [4:0] wr_idx = aw_addr_q[IDX_MSB:IDX_LSB];
  wire wr_sig = aw_addr_q[CORE_VIEW_BIT];
  wire lane0 = w_strb_q[0];
  wire lane1 = w_strb_q[1];
  wire wr_mapped = wr_idx == IDX_CONTROL || wr_idx == IDX_RESULT ||
    wr_idx == IDX_DEC_STATUS || wr_idx == IDX_IRQ_STATUS ||
    wr_idx == IDX_IRQ_MASK || wr_idx == IDX_CORE_CTRL;
  wire wr_ctrl = wr_fire && wr_idx == IDX_CONTROL && lane1;
  wire wr_ctrl_sup = wr_ctrl && !wr_sig;
  wire wr_sel = wr_fire && wr_idx == IDX_DEC_STATUS && lane0;
  wire wr_sel_sup = wr_sel && !wr_sig;
  wire wr_sel_sig = wr_sel && wr_sig;
  wire [1:0] wr_sel_val = w_data_q[MEAS_SEL_LSB+1:MEAS_SEL_LSB];
  wire wr_sel_active = signal_core_enable_flag ? wr_sel_sig : wr_sel_sup;
  wire meas_start = wr_sel_active && wr_sel_val != MEAS_SEL_OFF;
  wire meas_stop = wr_sel_active && wr_sel_val == MEAS_SEL_OFF;
  wire [1:0] meas_sel_active =
    signal_core_enable_flag ? meas_sel_sig : meas_sel_sup;

  // AXI write channel handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_data_q <= wdata[15:0];
        w_strb_q <= wstrb[1:0];
      end
      if (wr_fire) begin
        awready <= 1'b1;
        wready <= 1'b1;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Converter control fields; the signal core may only touch the middle bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_one_en <= 1'b0;
      dec_two_en <= 1'b0;
      irq_core_sel <= 1'b0;
      clk_slow_sel <= 1'b0;
      filt_irq_en <= '0;
    end else if (wr_ctrl) begin
      if (wr_ctrl_sup) begin
        dec_one_en <= w_data_q[DEC1_EN_BIT];
        dec_two_en <= w_data_q[DEC2_EN_BIT];
        irq_core_sel <= w_data_q[IRQ_CORE_BIT];
      end
      clk_slow_sel <= w_data_q[CLK_SLOW_BIT];
      filt_irq_en <= w_data_q[IRQ_EN_LSB+IRQ_EN_N-1:IRQ_EN_LSB];
    end
  end

  // Per-core select copies and the core enable flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_sel_sup <= MEAS_SEL_RESET;
      meas_sel_sig <= MEAS_SEL_RESET;
      signal_core_enable_flag <= 1'b0;
    end else begin
      if (wr_sel_sup) meas_sel_sup <= wr_sel_val;
      if (wr_sel_sig) meas_sel_sig <= wr_sel_val;
      if (wr_fire && wr_idx == IDX_CORE_CTRL && lane0 && !wr_sig)
        signal_core_enable_flag <= w_data_q[SIG_EN_BIT];
    end
  end

  // Decoder outputs, mode forced only while the decoder runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec1_run <= 1'b0;
      dec2_run <= 1'b0;
      dec1_diff_mode <= 1'b0;
      dec2_diff_mode <= 1'b0;
      decoder_clock_slow <= 1'b0;
    end else begin
      dec1_run <= dec_one_en;
      dec2_run <= dec_two_en;
      dec1_diff_mode <= dec_one_en && port_output_p0_3;
      dec2_diff_mode <= dec_two_en && port_output_p2_0;
      decoder_clock_slow <= clk_slow_sel;
    end
  end

  // Clock measurement: divider gives the 32 kHz tick, window counts ticks
  wire measuring = meas_state == MEAS_RUN;
  wire tick = measuring && div_cnt == 16'(TICK_CYCLES - 1);
  wire meas_done = tick && tick_cnt == 16'(WINDOW_TICKS - 1);
  wire sync_hit = meas_dec == MEAS_SEL_OFF ? 1'b0 : sync_bit_pulse[meas_dec];
  wire [15:0] next_count =
    (sync_hit && sync_count != 16'hffff) ? sync_count + 16'h0001 : sync_count;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_state <= MEAS_IDLE;
      div_cnt <= '0;
      tick_cnt <= '0;
      sync_count <= '0;
      meas_dec <= MEAS_SEL_RESET;
      result <= RESULT_RESET;
    end else if (meas_start) begin
      // A second start restarts the window rather than queueing
      meas_state <= MEAS_RUN;
      div_cnt <= '0;
      tick_cnt <= '0;
      sync_count <= '0;
      meas_dec <= wr_sel_val;
      result <= RESULT_RESET;
    end else if (meas_stop) begin
      meas_state <= MEAS_IDLE;
    end else if (measuring) begin
      sync_count <= next_count;
      div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
      if (tick) tick_cnt <= tick_cnt + 16'h0001;
      if (meas_done) begin
        meas_state <= MEAS_IDLE;
        result <= next_count;
      end
    end
  end

  // Interrupt status: set wins over clear; filter flags clear only by owner
  wire owner_writes = wr_sig == irq_core_sel;
  wire wr_status = wr_fire && wr_idx == IDX_IRQ_STATUS && lane0;
  wire [EV_W-1:0] ev_set = {meas_done, filter_buf_flag};
  wire [EV_W-1:0] ev_clr = wr_status ?
    {w_data_q[EV_DONE_BIT], owner_writes ? w_data_q[FILT_N-1:0] : 6'h00} :
    EV_RESET;
  wire [EV_W-1:0] next_status = (ev_status & ~ev_clr) | ev_set;
  wire [FILT_N-1:0] filt_pend = ev_status[FILT_N-1:0] &
    {{2{filt_irq_en[2]}}, {2{filt_irq_en[1]}}, {2{filt_irq_en[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_status <= EV_RESET;
      ev_mask <= EV_RESET;
      irq <= 1'b0;
      irq_supervisory <= 1'b0;
      irq_signal <= 1'b0;
    end else begin
      ev_status <= next_status;
      if (wr_fire && wr_idx == IDX_IRQ_MASK && lane0)
        ev_mask <= w_data_q[EV_W-1:0];
      irq <= |({ev_status[EV_DONE_BIT], filt_pend} & ev_mask);
      irq_supervisory <= !irq_core_sel && |filt_pend;
      irq_signal <= irq_core_sel && |filt_pend;
    end
  end

  // Read path; unmapped words answer DECERR with zero data
  wire [4:0] rd_idx = araddr[IDX_MSB:IDX_LSB];
  wire rd_sig = araddr[CORE_VIEW_BIT];
  wire [15:0] rd_control = {irq_core_sel, filt_irq_en, clk_slow_sel,
    dec_two_en, dec_one_en, 9'h000};
  wire [1:0] rd_sel = rd_sig ? meas_sel_sig : meas_sel_sup;
  wire rd_mapped = rd_idx == IDX_CONTROL || rd_idx == IDX_RESULT ||
    rd_idx == IDX_DEC_STATUS || rd_idx == IDX_IRQ_STATUS ||
    rd_idx == IDX_IRQ_MASK || rd_idx == IDX_CORE_CTRL;
  wire [15:0] rd_word =
    rd_idx == IDX_CONTROL ? rd_control :
    rd_idx == IDX_RESULT ? result :
    rd_idx == IDX_DEC_STATUS ? {10'h000, rd_sel, 4'h0} :
    rd_idx == IDX_IRQ_STATUS ? {9'h000, ev_status} :
    rd_idx == IDX_IRQ_MASK ? {9'h000, ev_mask} :
    rd_idx == IDX_CORE_CTRL ? {15'h0000, signal_core_enable_flag} :
    16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {16'h0000, rd_word};
      rresp <= rd_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // Helper: cycles spent in the current measurement
  logic [31:0] meas_elapsed;
  always_ff @(posedge aclk) begin
    if (!aresetn || meas_start) meas_elapsed <= '0;
    else if (measuring) meas_elapsed <= meas_elapsed + 32'h1;
  end

  a_dec1_run_follow: assert property (
    wr_ctrl_sup |-> ##2 dec1_run == $past(w_data_q[DEC1_EN_BIT], 2))
    else $error("decoder 1 run does not follow its enable");
  a_dec1_mode_src: assert property (
    ##1 dec1_diff_mode == $past(dec_one_en && port_output_p0_3))
    else $error("decoder 1 mode does not follow port bit");
  a_dec2_run_follow: assert property (
    wr_ctrl_sup |-> ##2 dec2_run == $past(w_data_q[DEC2_EN_BIT], 2))
    else $error("decoder 2 run does not follow its enable");
  a_dec2_mode_src: assert property (
    ##1 dec2_diff_mode == $past(dec_two_en && port_output_p2_0))
    else $error("decoder 2 mode does not follow port bit");
  a_sig_write_guard: assert property (
    wr_ctrl && wr_sig |=> $stable({dec_one_en, dec_two_en, irq_core_sel}))
    else $error("signal core changed a protected bit");
  a_clk_speed_follow: assert property (
    wr_ctrl |-> ##2 decoder_clock_slow == $past(w_data_q[CLK_SLOW_BIT], 2))
    else $error("clock speed select not applied");
  a_filt_irq_route: assert property (
    ##1 {irq_supervisory, irq_signal} == ($past(|filt_pend) ?
      {!$past(irq_core_sel), $past(irq_core_sel)} : 2'b00))
    else $error("filter interrupt routed to wrong core");
  a_result_reset: assert property (
    $rose(aresetn) |-> result == RESULT_RESET)
    else $error("result not zero after reset");
  a_window_length: assert property (
    meas_done |-> meas_elapsed == 32'(WINDOW_TICKS * TICK_CYCLES - 1))
    else $error("measurement window length wrong");
  a_start_busy: assert property (
    meas_start |=> measuring && result == RESULT_RESET)
    else $error("measurement start not shown as busy");
  a_disable_code: assert property (
    meas_stop |=> !measuring ##1 !measuring)
    else $error("disable code started a measurement");
  a_active_copy: assert property (
    meas_start |-> (wr_sig == signal_core_enable_flag) ##1
      (meas_sel_active == $past(wr_sel_val)))
    else $error("measurement started from inactive copy");
  a_result_readonly: assert property (
    wr_fire && wr_idx == IDX_RESULT && !measuring |=> $stable(result))
    else $error("result register changed by a write");

  c_meas_done: cover property (meas_done && result != RESULT_RESET);
  c_irq_signal: cover property (irq_signal && irq);
  c_sig_blocked: cover property (wr_ctrl && wr_sig && w_data_q[DEC1_EN_BIT]);
  c_restart: cover property (measuring && meas_start);
endmodule
`default_nettype wire

// ### decoder_filter_ctrl_pkg.sv
// Register map, field layout and timing constants of the decoder control block
`default_nettype none
package decoder_filter_ctrl_pkg;
  // Address layout: bit 7 picks the view of the signal-processing core
  localparam int ADDR_W = 8;
  localparam int CORE_VIEW_BIT = 7;
  localparam int IDX_MSB = 6;
  localparam int IDX_LSB = 2;
  // Register indices, byte address is four times the index
  localparam logic [4:0] IDX_CONTROL = 5'h10;
  localparam logic [4:0] IDX_RESULT = 5'h12;
  localparam logic [4:0] IDX_DEC_STATUS = 5'h13;
  localparam logic [4:0] IDX_IRQ_STATUS = 5'h14;
  localparam logic [4:0] IDX_IRQ_MASK = 5'h15;
  localparam logic [4:0] IDX_CORE_CTRL = 5'h16;
  // Converter control fields
  localparam int DEC1_EN_BIT = 9;
  localparam int DEC2_EN_BIT = 10;
  localparam int CLK_SLOW_BIT = 11;
  localparam int IRQ_EN_LSB = 12;
  localparam int IRQ_EN_N = 3;
  localparam int IRQ_CORE_BIT = 15;
  // Measurement select field and its disable code
  localparam int MEAS_SEL_LSB = 4;
  localparam logic [1:0] MEAS_SEL_OFF = 2'h3;
  localparam logic [1:0] MEAS_SEL_RESET = 2'h3;
  // Core control
  localparam int SIG_EN_BIT = 0;
  // Event status layout
  localparam int FILT_N = 6;
  localparam int EV_DONE_BIT = 6;
  localparam int EV_W = 7;
  // Reset values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [EV_W-1:0] EV_RESET = 7'h00;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SLOW_CLK_HZ = 32768;
  localparam int TICK_CYCLES_DEF = CLK_HZ / SLOW_CLK_HZ;
  localparam int WINDOW_LOG2 = 9;
  localparam int WINDOW_TICKS_DEF = 1 << WINDOW_LOG2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic {
    MEAS_IDLE = 1'b0,
    MEAS_RUN = 1'b1
  } meas_state_e;
endpackage
`default_nettype wire

// ### modulator_model.sv
// Behavioural delta-sigma modulator link: decoder sync bits and filter flags
`timescale 1ns/1ns
`default_nettype none
module modulator_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench requests
  input wire logic go,
  input wire logic [1:0] chan,
  input wire logic [3:0] count,
  input wire logic [5:0] filt_req,
  // Decoders powered on the link
  input wire logic [2:0] dec_on,
  // Toward the block
  output logic [2:0] sync_bit_pulse,
  output logic [5:0] filter_buf_flag
);
  logic [3:0] left;
  logic ph;
  // Sync bits spaced two cycles apart so each pulse stands alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left <= '0;
      ph <= 1'b0;
      sync_bit_pulse <= '0;
      filter_buf_flag <= '0;
    end else begin
      filter_buf_flag <= filt_req;
      ph <= ~ph;
      sync_bit_pulse <= '0;
      if (go) begin
        left <= count;
        ph <= 1'b0;
      end else if (left != 4'h0 && ph) begin
        left <= left - 4'h1;
        // A disabled decoder never sees a sync bit
        sync_bit_pulse[chan] <= dec_on[chan];
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_decoder_filter_ctrl_clock_measure.sv
// Register-level bench of the decoder control and clock measurement block
`timescale 1ns/1ns
`default_nettype none
module tb_decoder_filter_ctrl_clock_measure;
  import decoder_filter_ctrl_pkg::*;
  localparam logic [7:0] CTL = {1'b0, IDX_CONTROL, 2'b00};
  localparam logic [7:0] RES = {1'b0, IDX_RESULT, 2'b00};
  localparam logic [7:0] SEL = {1'b0, IDX_DEC_STATUS, 2'b00};
  localparam logic [7:0] IST = {1'b0, IDX_IRQ_STATUS, 2'b00};
  localparam logic [7:0] IMK = {1'b0, IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] CC = {1'b0, IDX_CORE_CTRL, 2'b00};
  localparam logic [7:0] SIG = 8'h80;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, go;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, count;
  logic [1:0] bresp, rresp, r, chan;
  logic port_output_p0_3, port_output_p2_0;
  logic [2:0] sync_bit_pulse;
  logic [5:0] filter_buf_flag, filt_req;
  logic dec1_run, dec2_run, dec1_diff_mode, dec2_diff_mode;
  logic decoder_clock_slow, irq_supervisory, irq_signal, irq;
  logic [15:0] d;
  int fail_count, n_tests, cyc;
  // Short window: 8 ticks of 4 cycles keeps each measurement at 32 cycles
  decoder_filter_ctrl_clock_measure #(.TICK_CYCLES(4), .WINDOW_TICKS(8)) uut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .port_output_p0_3, .port_output_p2_0,
    .sync_bit_pulse, .filter_buf_flag, .dec1_run, .dec2_run,
    .dec1_diff_mode, .dec2_diff_mode, .decoder_clock_slow,
    .irq_supervisory, .irq_signal, .irq);
  modulator_model partner (.aclk, .aresetn, .go, .chan, .count, .filt_req,
    .dec_on({dec2_run, dec1_run, 1'b1}), .sync_bit_pulse, .filter_buf_flag);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Whole run takes well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(input logic [7:0] a, input logic [15:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task rd(input logic [7:0] a);
    logic ar;
    ar = 1'b1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (ar && arready) begin
        ar = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        d = rdata[15:0];
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task fire(input logic [1:0] c, input logic [3:0] n);
    @(posedge aclk);
    chan <= c;
    count <= n;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask
  task flag(input logic [5:0] f);
    @(posedge aclk);
    filt_req <= f;
    @(posedge aclk);
    filt_req <= '0;
    cy(3);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, go} = '0;
    {awaddr, araddr, wdata, chan, count, filt_req, d, r} = '0;
    {port_output_p0_3, port_output_p2_0} = 2'b10;
    wstrb = 4'hf;
    aresetn = 1'b0;
    cy(5);
    aresetn <= 1'b1;
    rd(RES);
    chk("result", d, RESULT_RESET);
    chk("rresp", r, RESP_OKAY);
    rd(CTL);
    chk("control", d, 16'h0000);
    wr(CTL, 16'hfe00);
    cy(2);
    chk("run", {dec1_run, dec2_run, decoder_clock_slow}, 3'b111);
    chk("mode", {dec1_diff_mode, dec2_diff_mode}, 2'b10);
    port_output_p0_3 <= 1'b0;
    port_output_p2_0 <= 1'b1;
    cy(3);
    chk("mode", {dec1_diff_mode, dec2_diff_mode}, 2'b01);
    wr(SIG | CTL, 16'h0000);
    rd(CTL);
    chk("control", d, 16'h8600);
    chk("slow", decoder_clock_slow, 1'b0);
    wr(CTL, 16'h0000);
    cy(2);
    chk("off", {dec1_run, dec2_run, dec1_diff_mode, dec2_diff_mode}, 4'h0);
    wr(RES, 16'h1234);
    chk("bresp", r, RESP_OKAY);
    rd(RES);
    chk("result", d, 16'h0000);
    wr(8'h7c, 16'h0000);
    chk("bresp", r, RESP_DECERR);
    rd(8'h7c);
    chk("rresp", r, RESP_DECERR);
    // Single measurement on decoder 1 with the done interrupt unmasked
    wr(CTL, 16'h0600);
    wr(IMK, 16'h0040);
    wr(SEL, 16'h0010);
    rd(RES);
    chk("busy", d, 16'h0000);
    fire(2'h1, 4'h5);
    rd(RES);
    chk("busy", d, 16'h0000);
    cy(40);
    rd(RES);
    chk("result", d, 16'h0005);
    chk("irq", irq, 1'b1);
    wr(IMK, 16'h0000);
    cy(2);
    chk("irq", irq, 1'b0);
    wr(IMK, 16'h0040);
    wr(IST, 16'h0040);
    cy(2);
    chk("irq", irq, 1'b0);
    rd(IST);
    chk("status", d, 16'h0000);
    // Control of the hardware moves to the other core's copy
    wr(CC, 16'h0001);
    wr(SEL, 16'h0010);
    rd(RES);
    chk("result", d, 16'h0005);
    wr(SIG | SEL, 16'h0020);
    rd(RES);
    chk("busy", d, 16'h0000);
    fire(2'h2, 4'h3);
    cy(40);
    rd(RES);
    chk("result", d, 16'h0003);
    rd(SEL);
    chk("sel", d & 16'h0030, 16'h0010);
    wr(SIG | SEL, 16'h0020);
    wr(SIG | SEL, 16'h0030);
    fire(2'h2, 4'h3);
    cy(40);
    rd(RES);
    chk("abort", d, 16'h0000);
    // Filter interrupt routing and clearing rights
    wr(CTL, 16'h1000);
    flag(6'h01);
    chk("route", {irq_supervisory, irq_signal}, 2'b10);
    wr(SIG | IST, 16'h0001);
    cy(2);
    chk("route", {irq_supervisory, irq_signal}, 2'b10);
    wr(IST, 16'h0001);
    cy(2);
    chk("route", {irq_supervisory, irq_signal}, 2'b00);
    wr(CTL, 16'h9000);
    flag(6'h04);
    chk("gate", {irq_supervisory, irq_signal}, 2'b00);
    wr(SIG | IST, 16'h003f);
    for (int i = 0; i < 3; i++) begin
      wr(CTL, 16'h8000 | (16'h1000 << i));
      flag(6'h02 << (2 * i));
      chk("route", {irq_supervisory, irq_signal}, 2'b01);
      wr(IST, 16'h003f);
      cy(2);
      chk("route", irq_signal, 1'b1);
      wr(SIG | IST, 16'h003f);
      cy(2);
      chk("route", irq_signal, 1'b0);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
